/* File: common/ppec_pkg.sv */
// Shared constants for the platform power event control block.
// Assumes one 10 MHz always-on clock shared by both ends.
// Functional notes
// - Held button forces soft-off from any state
// - Override period writable, resets to four seconds
// - Level bit shows debounced or raw button
// - Debounce adds 16 ms before press handling
// - Wake line falling edge raises event, and wakes when enabled
// - Internal wake request sets its own status
// - Reset button recognised by edge or 16 ms
// - Button reset pulse lasts 5 to 6 ms
// - Rearm after release and full running state
// - Power-cycle select turns reset into cycle
// - Reset button acts only with power good
// - Thermal trip drops deep sleeps within 1 us
// - Thermal glitches under 25 ns ignored
// - Trip monitoring window follows valid point
// - Thermal trip clears button event status
// - Holdoff delays resume only during exit
// - No flash access while sleeping or held
// - Controller holds well reset until flash done
// - Controller holdoff only after boot, 5 ms watch
// - Enhanced host interface disables holdoff
// - Power good low forces platform reset asynchronously
// - Board keeps power good free of glitches
// - Board holds link power 99 ms before power good

`default_nettype none

package ppec_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // Debounce delay
  localparam int unsigned DEB_MS = 16;
  localparam int unsigned DEB_CYC = DEB_MS * CYC_PER_MS;
  // Button reset pulse, least time rounded up
  localparam int unsigned RST_MIN_US = 5000;
  localparam int unsigned RST_MAX_US = 6000;
  localparam int unsigned RST_CYC = (RST_MIN_US * CYC_PER_MS + 999) / 1000;
  // Power-cycle off time for the cycle variant of the button reset
  localparam int unsigned PCYC_MS = 100;
  localparam int unsigned PCYC_CYC = PCYC_MS * CYC_PER_MS;
  // Override period in seconds
  localparam int unsigned SEC_CYC = CLK_HZ;
  localparam logic [3:0] OVR_DEFAULT_S = 4'h4;
  localparam logic [3:0] OVR_MIN_S = 4'h4;
  localparam logic [3:0] OVR_MAX_S = 4'he;
  // Thermal trip response bound and glitch filter
  localparam int unsigned TRIP_MAX_NS = 1000;
  localparam int unsigned TRIP_MAX_CYC = TRIP_MAX_NS / CLK_NS;
  localparam int unsigned GLITCH_NS = 25;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRIP_SAMPLES = GLITCH_CYC + 1;
  // Controller chip-select watch window
  localparam int unsigned WATCH_MS = 5;
  localparam int unsigned WATCH_CYC = WATCH_MS * CYC_PER_MS;

  typedef enum logic [2:0] {ST_OFF, ST_EXIT, ST_S0, ST_HRST, ST_CYCLE} ppec_state_e;
  typedef enum logic [2:0] {EC_G3, EC_WAIT_BOOT, EC_ARMED, EC_WATCH, EC_ACCESS} ppec_ec_state_e;
endpackage

`default_nettype wire

/* File: common/ppec_link_if.sv */
// Link between the power event device and the embedded controller.
// Assumes both ends run on the same always-on clock.

`default_nettype none

interface ppec_link_if;
  logic aux_sleep_n;
  logic flash_select_zero_n;
  logic platform_reset_n;
  logic resume_holdoff_n;
  logic resume_well_reset_n;

  modport dev (
    output aux_sleep_n,
    output flash_select_zero_n,
    output platform_reset_n,
    input resume_holdoff_n,
    input resume_well_reset_n
  );
  modport ec (
    input aux_sleep_n,
    input flash_select_zero_n,
    input platform_reset_n,
    output resume_holdoff_n,
    output resume_well_reset_n
  );
endinterface

`default_nettype wire

/* File: core/ppec_device.sv */
// Power event logic of the always-on well: buttons, wake, thermal trip,
// sleep outputs, platform reset and flash gating.
// Assumes pin inputs synchronous to clock; power good may drop any time.

`default_nettype none

module ppec_device #(
  parameter int unsigned DEB_CYCLES = ppec_pkg::DEB_CYC,
  parameter int unsigned RST_CYCLES = ppec_pkg::RST_CYC,
  parameter int unsigned PCYC_CYCLES = ppec_pkg::PCYC_CYC,
  parameter int unsigned SEC_CYCLES = ppec_pkg::SEC_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link to the embedded controller
  ppec_link_if.dev link,
  // Platform pins
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic thermal_trip_n,
  input wire logic pme_n,
  input wire logic internal_wake_req,
  input wire logic platform_power_good,
  // Configuration
  input wire logic button_debounce_bypass,
  input wire logic trip_valid_point,
  input wire logic reset_power_cycle,
  input wire logic espi_enable,
  input wire logic pme_wake_enable,
  input wire logic override_wr,
  input wire logic [3:0] override_seconds,
  // Software requests
  input wire logic sleep_req,
  input wire logic clear_button_event,
  input wire logic clear_wake_status,
  input wire logic clear_trip_status,
  input wire logic flash_req,
  // Sleep outputs
  output logic deep_sleep_a_n,
  output logic deep_sleep_b_n,
  // Status
  output logic button_level_status,
  output logic button_event_status,
  output logic pme_status,
  output logic internal_wake_status,
  output logic power_trip_status,
  output logic pm_event,
  output logic flash_grant,
  output logic [3:0] override_seconds_status
);
  ppec_pkg::ppec_state_e state_reg;
  ppec_pkg::ppec_state_e state_next;
  logic well_rst;
  logic [1:0] raw_low;
  logic [1:0] deb_low;
  logic [1:0] pressed;
  logic [1:0] pressed_prev_reg;
  logic [31:0] sec_div_reg;
  logic [3:0] secs_reg;
  logic ovr_fired_reg;
  logic ovr_hit;
  logic [ppec_pkg::TRIP_SAMPLES-1:0] trip_hist_reg;
  logic trip_mon_reg;
  logic trip;
  logic rb_armed_reg;
  logic rb_rec;
  logic pcyc_sel_reg;
  logic [31:0] tmr_reg;
  logic pme_prev_reg;
  logic iwake_prev_reg;
  logic pme_fall;
  logic iwake_rise;
  logic wake;
  logic holdoff_active;
  logic aux_now;
  logic flash_ok;
  logic prst_reg;
  logic aux_reg;

  // Resume-well reset from the controller acts as a second sync reset
  assign well_rst = rst | ~link.resume_well_reset_n;
  assign raw_low = {~reset_button_n, ~power_button_n};

  // Debounce per button: asserts after DEB_CYCLES low, releases at once
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_deb
      logic [31:0] cnt_reg;
      logic low_reg;
      always_ff @(posedge clock) begin
        if (well_rst || !raw_low[g]) begin
          cnt_reg <= '0;
          low_reg <= 1'b0;
        end else if (cnt_reg == DEB_CYCLES - 1) begin
          low_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
      assign deb_low[g] = low_reg;
    end
  endgenerate

  // Bypass selects the raw pin for both buttons
  assign pressed = button_debounce_bypass ? raw_low : deb_low;

  // Edge history of buttons and wake lines
  always_ff @(posedge clock) begin
    if (well_rst) begin
      pressed_prev_reg <= 2'h0;
      pme_prev_reg <= 1'b1;
      iwake_prev_reg <= 1'b0;
    end else begin
      pressed_prev_reg <= pressed;
      pme_prev_reg <= pme_n;
      iwake_prev_reg <= internal_wake_req;
    end
  end
  assign pme_fall = pme_prev_reg & ~pme_n;
  assign iwake_rise = internal_wake_req & ~iwake_prev_reg;

  // Override period; out-of-range writes are dropped
  always_ff @(posedge clock) begin
    if (well_rst) begin
      override_seconds_status <= ppec_pkg::OVR_DEFAULT_S;
    end else if (override_wr && override_seconds >= ppec_pkg::OVR_MIN_S
                 && override_seconds <= ppec_pkg::OVR_MAX_S) begin
      override_seconds_status <= override_seconds;
    end
  end

  // Override timer: second divider pulse, restart on release
  assign ovr_hit = pressed[0] && !ovr_fired_reg && (sec_div_reg == SEC_CYCLES - 1)
                   && (secs_reg + 4'h1 == override_seconds_status);
  always_ff @(posedge clock) begin
    if (well_rst || !pressed[0]) begin
      sec_div_reg <= '0;
      secs_reg <= 4'h0;
      ovr_fired_reg <= 1'b0;
    end else if (ovr_hit) begin
      ovr_fired_reg <= 1'b1;
    end else if (!ovr_fired_reg) begin
      if (sec_div_reg == SEC_CYCLES - 1) begin
        sec_div_reg <= '0;
        secs_reg <= secs_reg + 4'h1;
      end else begin
        sec_div_reg <= sec_div_reg + 32'h1;
      end
    end
  end

  // Trip filter: needs consecutive low samples, so sub-cycle glitches vanish
  always_ff @(posedge clock) begin
    if (well_rst) begin
      trip_hist_reg <= '0;
    end else begin
      trip_hist_reg <= {trip_hist_reg[ppec_pkg::TRIP_SAMPLES-2:0], ~thermal_trip_n};
    end
  end

  // Monitoring window opens per valid point, always closes on power loss
  always_ff @(posedge clock) begin
    if (well_rst || !platform_power_good) begin
      trip_mon_reg <= 1'b0;
    end else if (trip_valid_point || prst_reg) begin
      trip_mon_reg <= 1'b1;
    end
  end
  assign trip = trip_mon_reg & (&trip_hist_reg);

  // Reset button: one shot, rearmed only after release in full S0
  assign rb_rec = platform_power_good && rb_armed_reg && (state_reg == ppec_pkg::ST_S0)
                  && pressed[1] && !pressed_prev_reg[1];
  always_ff @(posedge clock) begin
    if (well_rst) begin
      rb_armed_reg <= 1'b1;
      pcyc_sel_reg <= 1'b0;
    end else if (rb_rec) begin
      rb_armed_reg <= 1'b0;
      pcyc_sel_reg <= reset_power_cycle;
    end else if (!pressed[1] && state_reg == ppec_pkg::ST_S0 && prst_reg) begin
      rb_armed_reg <= 1'b1;
    end
  end

  // Wake sources seen while off
  assign wake = (pressed[0] && !pressed_prev_reg[0])
                || (pme_wake_enable && (pme_fall || iwake_rise));
  assign holdoff_active = !espi_enable && !link.resume_holdoff_n;

  // Next state; trip and override win over every other event except a wake in ST_OFF
  always_comb begin
    state_next = state_reg;
    if ((trip || ovr_hit) && state_reg != ppec_pkg::ST_OFF) begin
      state_next = ppec_pkg::ST_OFF;
    end else begin
      unique case (state_reg)
        ppec_pkg::ST_OFF: if (wake) state_next = ppec_pkg::ST_EXIT;
        ppec_pkg::ST_EXIT: if (!holdoff_active) state_next = ppec_pkg::ST_S0;
        ppec_pkg::ST_S0: begin
          if (rb_rec) state_next = ppec_pkg::ST_HRST;
          else if (sleep_req) state_next = ppec_pkg::ST_OFF;
        end
        ppec_pkg::ST_HRST: begin
          if (tmr_reg == RST_CYCLES - 1) begin
            state_next = pcyc_sel_reg ? ppec_pkg::ST_CYCLE : ppec_pkg::ST_S0;
          end
        end
        ppec_pkg::ST_CYCLE: if (tmr_reg == PCYC_CYCLES - 1) state_next = ppec_pkg::ST_EXIT;
      endcase
    end
  end

  // State register; timer restarts on every state change
  always_ff @(posedge clock) begin
    if (well_rst) begin
      state_reg <= ppec_pkg::ST_OFF;
      tmr_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= (state_next != state_reg) ? 32'h0 : tmr_reg + 32'h1;
    end
  end

  // Sleep outputs follow the state one cycle later, well inside 1 us
  assign aux_now = (state_reg != ppec_pkg::ST_OFF) && (state_reg != ppec_pkg::ST_CYCLE);
  always_ff @(posedge clock) begin
    if (well_rst) begin
      deep_sleep_a_n <= 1'b0;
      deep_sleep_b_n <= 1'b0;
      aux_reg <= 1'b0;
    end else begin
      deep_sleep_a_n <= aux_now && state_reg != ppec_pkg::ST_EXIT;
      deep_sleep_b_n <= aux_now && state_reg != ppec_pkg::ST_EXIT;
      aux_reg <= aux_now;
    end
  end
  assign link.aux_sleep_n = aux_reg;

  // Platform reset: async on power loss, otherwise low outside plain S0
  always_ff @(posedge clock or negedge platform_power_good) begin
    if (!platform_power_good) begin
      prst_reg <= 1'b0;
    end else if (well_rst) begin
      prst_reg <= 1'b0;
    end else begin
      prst_reg <= (state_reg == ppec_pkg::ST_S0);
    end
  end
  assign link.platform_reset_n = prst_reg;

  // Flash gate: blocked while asleep or while holdoff still asserted
  assign flash_ok = aux_now && !holdoff_active;
  always_ff @(posedge clock) begin
    if (well_rst) begin
      flash_grant <= 1'b0;
    end else begin
      flash_grant <= flash_req && flash_ok;
    end
  end
  assign link.flash_select_zero_n = ~flash_grant;

  // Sticky status: set wins over software clear; trip clears button event
  always_ff @(posedge clock) begin
    if (well_rst) begin
      button_level_status <= 1'b0;
      button_event_status <= 1'b0;
      pme_status <= 1'b0;
      internal_wake_status <= 1'b0;
      power_trip_status <= 1'b0;
      pm_event <= 1'b0;
    end else begin
      button_level_status <= pressed[0];
      if (trip) button_event_status <= 1'b0;
      else if (pressed[0] && !pressed_prev_reg[0]) button_event_status <= 1'b1;
      else if (clear_button_event) button_event_status <= 1'b0;
      if (pme_fall) pme_status <= 1'b1;
      else if (clear_wake_status) pme_status <= 1'b0;
      if (iwake_rise) internal_wake_status <= 1'b1;
      else if (clear_wake_status) internal_wake_status <= 1'b0;
      if (trip) power_trip_status <= 1'b1;
      else if (clear_trip_status) power_trip_status <= 1'b0;
      pm_event <= pme_fall || iwake_rise;
    end
  end
endmodule

`default_nettype wire

/* File: core/ppec_controller.sv */
// Embedded controller end of the resume-holdoff handshake.
// Assumes the device end shares this clock through the link interface.

`default_nettype none

module ppec_controller #(
  parameter int unsigned WATCH_CYCLES = ppec_pkg::WATCH_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link to the device
  ppec_link_if.ec link,
  // Controller side
  input wire logic power_present,
  input wire logic flash_wanted,
  output logic ec_flash_grant,
  output logic holdoff_aborted
);
  ppec_pkg::ppec_ec_state_e state_reg;
  logic [31:0] tmr_reg;
  logic aux_prev_reg;
  logic rwr_reg;
  logic holdoff_n_reg;

  // Handshake sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ppec_pkg::EC_G3;
      tmr_reg <= '0;
      aux_prev_reg <= 1'b1;
      rwr_reg <= 1'b0;
      holdoff_n_reg <= 1'b1;
      ec_flash_grant <= 1'b0;
      holdoff_aborted <= 1'b0;
    end else begin
      aux_prev_reg <= link.aux_sleep_n;
      holdoff_aborted <= 1'b0;
      if (!power_present) begin
        state_reg <= ppec_pkg::EC_G3;
        rwr_reg <= 1'b0;
        holdoff_n_reg <= 1'b1;
        ec_flash_grant <= 1'b0;
      end else begin
        unique case (state_reg)
          ppec_pkg::EC_G3: begin
            // Own flash work runs with the well reset still held
            ec_flash_grant <= flash_wanted;
            if (!flash_wanted) begin
              rwr_reg <= 1'b1;
              state_reg <= ppec_pkg::EC_WAIT_BOOT;
            end
          end
          ppec_pkg::EC_WAIT_BOOT: begin
            if (link.platform_reset_n) state_reg <= ppec_pkg::EC_ARMED;
          end
          ppec_pkg::EC_ARMED: begin
            if (aux_prev_reg && !link.aux_sleep_n && flash_wanted) begin
              holdoff_n_reg <= 1'b0;
              tmr_reg <= '0;
              state_reg <= ppec_pkg::EC_WATCH;
            end
          end
          ppec_pkg::EC_WATCH: begin
            // Chip-select activity means a global reset: back off
            if (!link.flash_select_zero_n) begin
              holdoff_n_reg <= 1'b1;
              holdoff_aborted <= 1'b1;
              state_reg <= ppec_pkg::EC_WAIT_BOOT;
            end else if (tmr_reg == WATCH_CYCLES - 1) begin
              ec_flash_grant <= 1'b1;
              state_reg <= ppec_pkg::EC_ACCESS;
            end else begin
              tmr_reg <= tmr_reg + 32'h1;
            end
          end
          ppec_pkg::EC_ACCESS: begin
            if (!flash_wanted) begin
              ec_flash_grant <= 1'b0;
              holdoff_n_reg <= 1'b1;
              state_reg <= ppec_pkg::EC_ARMED;
            end
          end
          default: state_reg <= ppec_pkg::EC_G3;
        endcase
      end
    end
  end

  assign link.resume_well_reset_n = rwr_reg;
  assign link.resume_holdoff_n = holdoff_n_reg;
endmodule

`default_nettype wire

/* File: tb/ppec_asserts.sv */
// Checker for the power event link and the device's status and sleep pins.
// Assumes one clock; instantiated beside the link interface in the bench.

`default_nettype none

module ppec_asserts #(
  parameter int unsigned RST_CYCLES = ppec_pkg::RST_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link signals
  input wire logic aux_sleep_n,
  input wire logic flash_select_zero_n,
  input wire logic platform_reset_n,
  input wire logic resume_holdoff_n,
  // Device pins
  input wire logic platform_power_good,
  input wire logic thermal_trip_n,
  input wire logic pme_n,
  input wire logic internal_wake_req,
  input wire logic espi_enable,
  input wire logic deep_sleep_a_n,
  input wire logic deep_sleep_b_n,
  input wire logic button_event_status,
  input wire logic power_trip_status,
  input wire logic internal_wake_status,
  input wire logic pm_event
);
  int unsigned low_cnt;
  logic btn_rst;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Length of the current platform reset pulse
  always_ff @(posedge clock) begin
    if (platform_reset_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  // Pulse begun in full running state; sleep entries and power loss drop it
  always_ff @(posedge clock) begin
    if (rst || !aux_sleep_n || !deep_sleep_a_n || !platform_power_good) begin
      btn_rst <= 1'b0;
    end else if ($fell(platform_reset_n)) begin
      btn_rst <= 1'b1;
    end
  end

  a_pgood_low_reset: assert property (!platform_power_good |-> !platform_reset_n)
    else $error("platform reset released without power good");
  a_trip_drops_sleep: assert property ($rose(power_trip_status) |-> ##[0:2]
    (!deep_sleep_a_n && !deep_sleep_b_n)) else $error("trip without deep sleep");
  a_trip_needs_pin: assert property ($rose(power_trip_status) |->
    !$past(thermal_trip_n) && !$past(thermal_trip_n, 2)) else $error("trip from short pulse");
  a_trip_clears_button: assert property ($rose(power_trip_status) |->
    !button_event_status) else $error("button event kept over trip");
  a_no_flash_asleep: assert property (!aux_sleep_n |-> flash_select_zero_n)
    else $error("flash access while asleep");
  a_no_flash_holdoff: assert property (!resume_holdoff_n && !espi_enable |=>
    flash_select_zero_n) else $error("flash access under holdoff");
  a_pme_fall_event: assert property ($fell(pme_n) |-> ##[1:3] pm_event)
    else $error("wake line fall gave no event");
  a_wake_status_set: assert property ($rose(internal_wake_req) |->
    ##[1:3] internal_wake_status) else $error("internal wake not recorded");
  a_button_reset_len: assert property ($rose(platform_reset_n) && btn_rst |->
    low_cnt >= RST_CYCLES && low_cnt <= RST_CYCLES * 6 / 5) else $error("bad reset length");
  a_holdoff_keeps_exit: assert property ((!resume_holdoff_n && !espi_enable &&
    aux_sleep_n && !deep_sleep_a_n) [*2] |=> !deep_sleep_a_n) else $error("resume under holdoff");
  a_holdoff_when_asleep: assert property ($fell(resume_holdoff_n) |-> !aux_sleep_n)
    else $error("holdoff raised while awake");
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Bench joining the power event device and the controller through the link.
// Assumes short count parameters; all stimulus lands on rising clock edges.

`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DEB = 8;
  localparam int unsigned RSTC = 20;
  localparam int unsigned SEC = 10;
  localparam logic [3:0] WV [4] = '{4'hf, 4'h3, 4'he, 4'h5};
  localparam logic [3:0] WE [4] = '{4'h4, 4'h4, 4'he, 4'h5};
  logic clock, rst, pwr_btn_n, rst_btn_n, trip_n, pme_n, iwake, pgood;
  logic bypass, valid_pt, pcycle, espi, wake_en, ovr_wr, sleep_req;
  logic clr_btn, clr_wake, clr_trip, flash_req, present, ec_want;
  logic ds_a_n, ds_b_n, lvl, btn_evt, pme_sts, iw_sts, trip_sts, pm_evt, fgrant, ec_grant;
  logic [3:0] ovr_sec, ovr_stat;
  logic aborted, abort_seen;
  int error_cnt, checks_done, n;
  ppec_link_if link();

  // Both ends share the link; the checker watches it
  ppec_device #(.DEB_CYCLES(DEB), .RST_CYCLES(RSTC), .PCYC_CYCLES(10), .SEC_CYCLES(SEC))
    ppec_device_i (.clock(clock), .rst(rst), .link(link), .power_button_n(pwr_btn_n),
    .reset_button_n(rst_btn_n), .thermal_trip_n(trip_n), .pme_n(pme_n),
    .internal_wake_req(iwake), .platform_power_good(pgood), .button_debounce_bypass(bypass),
    .trip_valid_point(valid_pt), .reset_power_cycle(pcycle), .espi_enable(espi),
    .pme_wake_enable(wake_en), .override_wr(ovr_wr), .override_seconds(ovr_sec),
    .sleep_req(sleep_req), .clear_button_event(clr_btn), .clear_wake_status(clr_wake),
    .clear_trip_status(clr_trip), .flash_req(flash_req), .deep_sleep_a_n(ds_a_n),
    .deep_sleep_b_n(ds_b_n), .button_level_status(lvl), .button_event_status(btn_evt),
    .pme_status(pme_sts), .internal_wake_status(iw_sts), .power_trip_status(trip_sts),
    .pm_event(pm_evt), .flash_grant(fgrant), .override_seconds_status(ovr_stat));
  ppec_controller #(.WATCH_CYCLES(16)) ppec_controller_i (.clock(clock), .rst(rst),
    .link(link), .power_present(present), .flash_wanted(ec_want),
    .ec_flash_grant(ec_grant), .holdoff_aborted(aborted));
  ppec_asserts #(.RST_CYCLES(RSTC)) ppec_asserts_i (.clock(clock), .rst(rst),
    .aux_sleep_n(link.aux_sleep_n), .flash_select_zero_n(link.flash_select_zero_n),
    .platform_reset_n(link.platform_reset_n), .resume_holdoff_n(link.resume_holdoff_n),
    .platform_power_good(pgood), .thermal_trip_n(trip_n), .pme_n(pme_n),
    .internal_wake_req(iwake), .espi_enable(espi), .deep_sleep_a_n(ds_a_n),
    .deep_sleep_b_n(ds_b_n), .button_event_status(btn_evt), .power_trip_status(trip_sts),
    .internal_wake_status(iw_sts), .pm_event(pm_evt));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Abort is a one-cycle pulse; hold it for a later compare
  always_ff @(posedge clock) begin
    if (rst) begin
      abort_seen <= 1'b0;
    end else if (aborted) begin
      abort_seen <= 1'b1;
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic press(input int k);
    @(posedge clock) pwr_btn_n <= 1'b0;
    repeat (k) @(posedge clock);
    pwr_btn_n <= 1'b1;
    #1;
  endtask

  task automatic boot_chk();
    tick(12);
    chk({link.aux_sleep_n, ds_a_n, ds_b_n, link.platform_reset_n}, 4'hf);
  endtask

  // Trip while power good is low, then after it returns
  task automatic trip_try(input logic vp, input logic exp);
    for (int p = 0; p < 2; p++) begin
      @(posedge clock) pgood <= p[0];
      valid_pt <= vp;
      tick(3);
      @(posedge clock) trip_n <= 1'b0;
      tick(4);
      @(posedge clock) trip_n <= 1'b1;
      tick(4);
      chk(trip_sts, p[0] & exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 560 cycles
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    summarize();
  end

  initial begin
    {pwr_btn_n, rst_btn_n, trip_n, pme_n, bypass, wake_en, present, rst} = 8'hff;
    {iwake, pgood, valid_pt, pcycle, espi, ovr_wr, sleep_req} = 7'h00;
    {clr_btn, clr_wake, clr_trip, flash_req, ec_want} = 5'h00;
    ovr_sec = 4'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    chk({ovr_stat, ds_a_n, link.aux_sleep_n, link.platform_reset_n}, 7'h20);
    // Writes outside 4..14 are refused
    foreach (WV[i]) begin
      @(posedge clock) ovr_wr <= 1'b1;
      ovr_sec <= WV[i];
      @(posedge clock) ovr_wr <= 1'b0;
      tick(2);
      chk(ovr_stat, WE[i]);
    end
    @(posedge clock) pgood <= 1'b1; // Clean edge, long after power-up
    press(2);
    boot_chk();
    // Debounced level lags the raw pin
    @(posedge clock) bypass <= 1'b0;
    pwr_btn_n <= 1'b0;
    tick(DEB - 3);
    chk(lvl, 1'b0);
    tick(5);
    chk(lvl, 1'b1);
    @(posedge clock) pwr_btn_n <= 1'b1;
    bypass <= 1'b1;
    // Override after five seconds, once per press
    @(posedge clock) pwr_btn_n <= 1'b0;
    tick(SEC * 5 - 6);
    chk(ds_a_n, 1'b1);
    tick(10);
    chk({ds_a_n, ds_b_n}, 2'b00);
    tick(30);
    chk(ds_a_n, 1'b0);
    @(posedge clock) pwr_btn_n <= 1'b1;
    @(posedge clock) pme_n <= 1'b0;
    tick(2);
    chk(pme_sts, 1'b1);
    boot_chk();
    @(posedge clock) pme_n <= 1'b1;
    clr_wake <= 1'b1;
    @(posedge clock) clr_wake <= 1'b0;
    tick(3);
    chk(pme_sts, 1'b0);
    @(posedge clock) iwake <= 1'b1;
    tick(3);
    chk(iw_sts, 1'b1);
    // Reset button held: one pulse of fixed length only
    @(posedge clock) rst_btn_n <= 1'b0;
    tick(3);
    chk(link.platform_reset_n, 1'b0);
    n = 1;
    while (!link.platform_reset_n && n < 100) begin
      tick(1);
      n++;
    end
    chk(n >= RSTC - 1 && n <= RSTC * 6 / 5, 1'b1);
    tick(30);
    chk(link.platform_reset_n, 1'b1);
    @(posedge clock) rst_btn_n <= 1'b1;
    pcycle <= 1'b1;
    tick(3);
    @(posedge clock) rst_btn_n <= 1'b0;
    @(posedge clock) rst_btn_n <= 1'b1;
    tick(RSTC + 5);
    chk(link.aux_sleep_n, 1'b0);
    tick(20);
    boot_chk();
    @(posedge clock) pcycle <= 1'b0;
    pgood <= 1'b0;
    #1;
    chk(link.platform_reset_n, 1'b0);
    @(posedge clock) rst_btn_n <= 1'b0;
    tick(3);
    @(posedge clock) rst_btn_n <= 1'b1;
    pgood <= 1'b1;
    tick(5);
    chk(link.platform_reset_n, 1'b1);
    // Thermal trip clears the button event
    @(posedge clock) clr_btn <= 1'b1;
    @(posedge clock) clr_btn <= 1'b0;
    tick(2);
    chk(btn_evt, 1'b0);
    press(2);
    tick(2);
    chk(btn_evt, 1'b1);
    @(posedge clock) trip_n <= 1'b0;
    @(posedge clock) trip_n <= 1'b1;
    tick(6);
    chk(trip_sts, 1'b0);
    @(posedge clock) trip_n <= 1'b0;
    tick(10);
    chk({ds_a_n, ds_b_n, trip_sts, btn_evt}, 4'h2);
    @(posedge clock) trip_n <= 1'b1;
    // Clear only after the filter has emptied, or the set wins
    tick(3);
    @(posedge clock) clr_trip <= 1'b1;
    @(posedge clock) clr_trip <= 1'b0;
    trip_try(1'b0, 1'b0);
    trip_try(1'b1, 1'b1);
    press(2);
    boot_chk();
    // Controller holds the exit while it uses the flash; with espi set the exit goes ahead
    for (int e = 0; e < 2; e++) begin
      @(posedge clock) espi <= e[0];
      ec_want <= 1'b1;
      sleep_req <= 1'b1;
      @(posedge clock) sleep_req <= 1'b0;
      tick(28);
      chk({ec_grant, link.resume_holdoff_n}, 2'b10);
      @(posedge clock) flash_req <= 1'b1;
      press(2);
      tick(12);
      chk({ds_a_n, fgrant}, {e[0], e[0]});
      @(posedge clock) ec_want <= 1'b0;
      boot_chk();
      chk(fgrant, 1'b1);
      @(posedge clock) flash_req <= 1'b0;
    end
    // Power-cycle reset: flash use inside the watch window aborts the holdoff
    @(posedge clock) pcycle <= 1'b1;
    ec_want <= 1'b1;
    flash_req <= 1'b1;
    rst_btn_n <= 1'b0;
    @(posedge clock) rst_btn_n <= 1'b1;
    tick(RSTC + 30);
    chk({ec_grant, link.resume_holdoff_n, abort_seen}, 3'h3);
    summarize();
  end
endmodule

`default_nettype wire
